// ===== verilog/dac_decode_top.sv
// backplane slave select, strap configuration and converter update control
// assumes backplane pins are asynchronous and an avalon master on clock
`include "dac_decode_defs.svh"

module dac_decode_top (
   input wire logic clock,
   input wire logic reset,
   // backplane side
   input wire dac_decode_pkg::vme_pins_t vme_in,
   output logic [15:0] vme_data_out,
   output logic vme_data_oe,
   output logic vme_dtack_n_out,
   output logic vme_dtack_oe,
   // straps, switches and trigger pin
   input wire dac_decode_pkg::config_pins_t config_in,
   input wire logic external_update_trigger_in,
   // converter latches
   output dac_decode_pkg::dac_bank_t dac_code,
   output logic update_strobe,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import dac_decode_pkg::*;

   vme_pins_t vp;
   config_pins_t cp;
   logic trig_s;

   // every pin group passes two flops before any decode looks at it
   pin_sync #(.WIDTH($bits(vme_pins_t))) u_sync_vme (
      .clock(clock),
      .reset(reset),
      .async_in(vme_in),
      .sync_out(vp)
   );

   pin_sync #(.WIDTH($bits(config_pins_t))) u_sync_cfg (
      .clock(clock),
      .reset(reset),
      .async_in(config_in),
      .sync_out(cp)
   );

   pin_sync #(.WIDTH(1)) u_sync_trig (
      .clock(clock),
      .reset(reset),
      .async_in(external_update_trigger_in),
      .sync_out(trig_s)
   );

   // strap decode into operating modes
   logic mode_program;
   logic mode_external;
   logic mode_twos;
   logic [5:0] am_expected;
   logic [10:0] base_cmp;

   assign mode_program = cp.program_update_strap;
   assign mode_external = cp.program_update_strap & cp.external_trigger_strap;
   // both or neither coding strap installed falls back to offset binary
   assign mode_twos = cp.twos_complement_strap & ~cp.offset_binary_strap;
   assign am_expected = cp.access_privilege_strap ? `AM_NONPRIVILEGED
                                                  : `AM_SUPERVISORY;
   // switch on demands a zero; factory all-on high and 100 low gives 0060
   assign base_cmp = ~{cp.high_base_select_switches,
                       cp.low_base_select_switches[2:0]};

   // backplane state
   vme_state_t vstate_q, vstate_d;
   logic [15:0] vdata_q, vdata_d;
   logic vdata_oe_q, vdata_oe_d;
   logic dtack_oe_q, dtack_oe_d;
   logic [15:0] cycles_q, cycles_d;
   logic [16:0] last_addr_q, last_addr_d;
   logic decode_en_q, decode_en_d;
   dac_bank_t dac_code_q, dac_code_d;
   logic seq_busy_q, seq_busy_d;

   logic hit;
   logic [4:0] win_ofs;
   logic [2:0] chan;
   logic [15:0] coded;
   logic stage_wr;
   logic imm_wr;
   logic csr_start;

   assign win_ofs = vp.addr[`WIN_OFS_W-1:0];
   assign chan = vp.addr[3:1];
   // converter latches always hold offset binary; twos input flips the sign
   assign coded = mode_twos ? {~vp.data[`DATA_MSB], vp.data[14:0]} : vp.data;

   // base, space and modifier must all agree before the board answers
   assign hit = decode_en_q
                & (vp.am == am_expected)
                & (vp.addr[15:`WINDOW_LSB] == base_cmp);

   // slave handshake: decode one cycle after strobes so address has settled
   always_comb begin
      vstate_d = vstate_q;
      vdata_d = vdata_q;
      vdata_oe_d = vdata_oe_q;
      dtack_oe_d = dtack_oe_q;
      cycles_d = cycles_q;
      last_addr_d = last_addr_q;
      stage_wr = 1'b0;
      imm_wr = 1'b0;
      csr_start = 1'b0;
      unique case (vstate_q)
         vme_idle: begin
            if (!vp.as_n && !vp.ds_n) begin
               vstate_d = vme_decode;
            end
         end
         vme_decode: begin
            if (vp.as_n || vp.ds_n) begin
               vstate_d = vme_idle;
            end else if (hit) begin
               vstate_d = vme_ack;
               dtack_oe_d = 1'b1;
               cycles_d = cycles_q + 16'h0001;
               last_addr_d = {~vp.write_n, vp.addr};
               if (!vp.write_n) begin
                  if (!win_ofs[4]) begin
                     stage_wr = 1'b1;
                     imm_wr = ~mode_program;
                  end else if (win_ofs == `WIN_CSR_OFS) begin
                     csr_start = vp.data[`CSR_START_BIT];
                  end
               end else begin
                  vdata_oe_d = 1'b1;
                  if (!win_ofs[4]) begin
                     vdata_d = mode_twos ? {~dac_code_q[chan][`DATA_MSB],
                                            dac_code_q[chan][14:0]}
                                         : dac_code_q[chan];
                  end else if (win_ofs == `WIN_CSR_OFS) begin
                     vdata_d = {10'h000, seq_busy_q, cp.access_privilege_strap,
                                mode_twos, mode_external, mode_program, ~mode_program};
                  end else begin
                     vdata_d = 16'h0000; // unused window words read zero
                  end
               end
            end else begin
               vstate_d = vme_ignore;
            end
         end
         vme_ack: begin
            // hold acknowledge until the master lifts its data strobe
            if (vp.ds_n) begin
               vstate_d = vme_idle;
               dtack_oe_d = 1'b0;
               vdata_oe_d = 1'b0;
            end
         end
         vme_ignore: begin
            // unselected: stay off the bus for the whole cycle
            if (vp.ds_n || vp.as_n) begin
               vstate_d = vme_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         vstate_q <= vme_idle;
         vdata_q <= 16'h0000;
         vdata_oe_q <= 1'b0;
         dtack_oe_q <= 1'b0;
         cycles_q <= 16'h0000;
         last_addr_q <= 17'h00000;
      end else begin
         vstate_q <= vstate_d;
         vdata_q <= vdata_d;
         vdata_oe_q <= vdata_oe_d;
         dtack_oe_q <= dtack_oe_d;
         cycles_q <= cycles_d;
         last_addr_q <= last_addr_d;
      end
   end

   // update sequencer walks the staging words into the output latches
   logic [2:0] seq_idx_q, seq_idx_d;
   logic seq_load_q, seq_load_d;
   logic [2:0] seq_load_idx_q, seq_load_idx_d;
   logic pend_q, pend_d;
   logic trig_prev_q;
   logic strobe_q, strobe_d;
   logic [15:0] stage_rdata;
   logic sw_update;
   logic trig_rise;

   dac_stage_mem u_stage (
      .clock(clock),
      .reset(reset),
      .write_en(stage_wr),
      .write_addr(chan),
      .write_data(coded),
      .read_addr(seq_idx_q),
      .read_data(stage_rdata)
   );

   assign trig_rise = trig_s & ~trig_prev_q;

   // a start loads all eight channels, one per cycle, under one strobe; an immediate write strobes for its one channel
   always_comb begin
      dac_code_d = dac_code_q;
      seq_busy_d = seq_busy_q;
      seq_idx_d = seq_idx_q;
      seq_load_d = 1'b0;
      seq_load_idx_d = seq_load_idx_q;
      pend_d = pend_q;
      strobe_d = 1'b0;
      if (seq_load_q) begin
         dac_code_d[seq_load_idx_q] = stage_rdata;
         strobe_d = (seq_load_idx_q == 3'h7);
      end
      if (seq_busy_q) begin
         seq_load_d = 1'b1;
         seq_load_idx_d = seq_idx_q;
         seq_idx_d = seq_idx_q + 3'h1;
         seq_busy_d = (seq_idx_q != 3'h7);
      end else if (pend_q) begin
         seq_busy_d = 1'b1;
         seq_idx_d = 3'h0;
         pend_d = 1'b0;
      end
      // a request arriving as the pending flag clears is kept: set wins
      if (mode_external) begin
         pend_d = pend_d | trig_rise;
      end else if (mode_program) begin
         pend_d = pend_d | csr_start | sw_update;
      end
      if (imm_wr) begin
         dac_code_d[chan] = coded;
         strobe_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         dac_code_q <= '0;
         seq_busy_q <= 1'b0;
         seq_idx_q <= 3'h0;
         seq_load_q <= 1'b0;
         seq_load_idx_q <= 3'h0;
         pend_q <= 1'b0;
         trig_prev_q <= 1'b0;
         strobe_q <= 1'b0;
      end else begin
         dac_code_q <= dac_code_d;
         seq_busy_q <= seq_busy_d;
         seq_idx_q <= seq_idx_d;
         seq_load_q <= seq_load_d;
         seq_load_idx_q <= seq_load_idx_d;
         pend_q <= pend_d;
         trig_prev_q <= trig_s;
         strobe_q <= strobe_d;
      end
   end

   // avalon slave: waitrequest drops for one cycle, the answer edge
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic avs_req;
   logic avs_take;

   assign avs_req = avs_read | avs_write;
   assign avs_take = avs_req & ~wait_q;
   assign sw_update = avs_take & avs_write & (avs_address == `AVS_CONTROL_OFS)
                      & avs_byteenable[0] & avs_writedata[`CTRL_UPDATE_REQ_BIT];

   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      decode_en_d = decode_en_q;
      if (avs_req && wait_q) begin
         wait_d = 1'b0;
         rdata_d = 32'h00000000; // unmapped offsets read zero
         unique case (avs_address)
            `AVS_STATUS_OFS: begin
               rdata_d[`ST_IMMEDIATE_BIT] = ~mode_program;
               rdata_d[`ST_PROGRAM_BIT] = mode_program;
               rdata_d[`ST_EXTERNAL_BIT] = mode_external;
               rdata_d[`ST_TWOS_BIT] = mode_twos;
               rdata_d[`ST_NONPRIV_BIT] = cp.access_privilege_strap;
               rdata_d[`ST_BUSY_BIT] = seq_busy_q | pend_q;
               rdata_d[`ST_BASE_LSB +: `BASE_CMP_W] = base_cmp;
            end
            `AVS_CONTROL_OFS: begin
               rdata_d[`CTRL_DECODE_EN_BIT] = decode_en_q;
            end
            `AVS_CYCLES_OFS: begin
               rdata_d[15:0] = cycles_q;
            end
            `AVS_LASTADDR_OFS: begin
               rdata_d[16:0] = last_addr_q;
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
      // write takes effect on the edge that sees waitrequest low
      if (avs_take && avs_write && (avs_address == `AVS_CONTROL_OFS)
          && avs_byteenable[0]) begin
         decode_en_d = avs_writedata[`CTRL_DECODE_EN_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
         decode_en_q <= `CTRL_RESET;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         decode_en_q <= decode_en_d;
      end
   end

   // outputs straight from flops except the dtack level, tied low; dtack is open drain, low when enabled
   assign vme_data_out = vdata_q;
   assign vme_data_oe = vdata_oe_q;
   assign vme_dtack_n_out = 1'b0;
   assign vme_dtack_oe = dtack_oe_q;
   assign dac_code = dac_code_q;
   assign update_strobe = strobe_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

endmodule : dac_decode_top

// ===== verilog/dac_decode_defs.svh
// constants for the backplane slave decode and strap configuration block
// assumes inclusion by bare name from the package and the top module
`ifndef DAC_DECODE_DEFS_SVH
`define DAC_DECODE_DEFS_SVH

// backplane widths
`define VME_ADDR_W 16
`define VME_AM_W 6
`define VME_DATA_W 16
`define CHAN_COUNT 8
`define CHAN_IDX_W 3

// base compare covers a15..a05; a04..a00 are zero in the base
`define WINDOW_LSB 5
`define BASE_CMP_W 11
`define LOW_SW_W 4
`define HIGH_SW_W 8

// address modifier codes for short i/o
`define AM_SUPERVISORY 6'h2d
`define AM_NONPRIVILEGED 6'h29

// offsets inside the 32-byte window (0060..006e data, 0070 control/status)
`define WIN_OFS_W 5
`define WIN_CSR_OFS 5'h10
`define CSR_START_BIT 0

// avalon slave register byte offsets
`define AVS_ADDR_W 4
`define AVS_STATUS_OFS 4'h0
`define AVS_CONTROL_OFS 4'h4
`define AVS_CYCLES_OFS 4'h8
`define AVS_LASTADDR_OFS 4'hc

// control register fields and reset value
`define CTRL_DECODE_EN_BIT 0
`define CTRL_UPDATE_REQ_BIT 1
`define CTRL_RESET 1'b1

// status register field positions
`define ST_IMMEDIATE_BIT 0
`define ST_PROGRAM_BIT 1
`define ST_EXTERNAL_BIT 2
`define ST_TWOS_BIT 3
`define ST_NONPRIV_BIT 4
`define ST_BUSY_BIT 5
`define ST_BASE_LSB 8

// code conversion: sign bit of a converter word
`define DATA_MSB 15

`endif

// ===== verilog/dac_decode_pkg.sv
// types for the backplane slave decode and strap configuration block
// assumes the defs header sits on the include path
`include "dac_decode_defs.svh"

package dac_decode_pkg;

   // backplane pins as seen by the slave, all from outside the clock domain
   typedef struct packed {
      logic [`VME_ADDR_W-1:0] addr;
      logic [`VME_AM_W-1:0] am;
      logic write_n;
      logic as_n;
      logic ds_n;
      logic [`VME_DATA_W-1:0] data;
   } vme_pins_t;

   // straps and base-select switches; a 1 means installed or switch on
   typedef struct packed {
      logic access_privilege_strap;
      logic offset_binary_strap;
      logic twos_complement_strap;
      logic program_update_strap;
      logic external_trigger_strap;
      logic [`HIGH_SW_W-1:0] high_base_select_switches;
      logic [`LOW_SW_W-1:0] low_base_select_switches;
   } config_pins_t;

   // converter output latches, one offset-binary word per channel
   typedef logic [`CHAN_COUNT-1:0][`VME_DATA_W-1:0] dac_bank_t;

   // slave handshake states
   typedef enum logic [1:0] {
      vme_idle,
      vme_decode,
      vme_ack,
      vme_ignore
   } vme_state_t;

endpackage : dac_decode_pkg

// ===== verilog/pin_sync.sv
// two-flop synchroniser for a group of pins
// assumes the group is quasi-static or qualified later by a strobe
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : pin_sync

// ===== verilog/dac_stage_mem.sv
// staging words for delayed update, one per converter channel
// assumes one writer and one reader; read data registered
module dac_stage_mem (
   input wire logic clock,
   input wire logic reset,
   input wire logic write_en,
   input wire logic [2:0] write_addr,
   input wire logic [15:0] write_data,
   input wire logic [2:0] read_addr,
   output logic [15:0] read_data
);

   logic [15:0] mem_q [0:7];
   logic [15:0] read_data_q;

   // array carries no reset; contents are defined by the first write
   always_ff @(posedge clock) begin
      if (write_en) begin
         mem_q[write_addr] <= write_data;
      end
   end

   // registered read, a same-cycle write is seen one cycle later
   always_ff @(posedge clock) begin
      if (reset) begin
         read_data_q <= 16'h0000;
      end else begin
         read_data_q <= mem_q[read_addr];
      end
   end

   assign read_data = read_data_q;

endmodule : dac_stage_mem

// ===== test/dac_decode_checker.sv
// assertions on the decode block's ports
// assumes bound to every instance of the decode top module
`include "dac_decode_defs.svh"

module dac_decode_checker (
   input wire logic clock,
   input wire logic reset,
   input wire dac_decode_pkg::vme_pins_t vme_in,
   input wire logic [15:0] vme_data_out,
   input wire logic vme_data_oe,
   input wire logic vme_dtack_n_out,
   input wire logic vme_dtack_oe,
   input wire dac_decode_pkg::config_pins_t config_in,
   input wire logic update_strobe,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 100ps;
   import dac_decode_pkg::*;
   logic am_ok;
   logic base_ok;
   logic hit;
   // raw straps are fine here: the bench changes them only while idle
   assign am_ok = vme_in.am == (config_in.access_privilege_strap ?
      `AM_NONPRIVILEGED : `AM_SUPERVISORY);
   assign base_ok = vme_in.addr[15:5] == ~{config_in.high_base_select_switches,
      config_in.low_base_select_switches[2:0]};
   assign hit = !vme_in.as_n && !vme_in.ds_n && am_ok && base_ok;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // bus phases
   sequence s_start; $fell(vme_in.as_n) && hit; endsequence
   sequence s_idle; vme_in.ds_n [*5]; endsequence
   sequence s_bad_am; (!vme_in.as_n && !am_ok) [*6]; endsequence
   sequence s_bad_base; (!vme_in.as_n && !base_ok) [*6]; endsequence
   sequence s_writing; (!vme_in.as_n && !vme_in.write_n) [*6]; endsequence
   a_ack_on_hit: assert property (s_start |-> ##[1:6] vme_dtack_oe)
      else $error("selected cycle not acknowledged");
   a_ack_holds: assert property (vme_dtack_oe && !vme_in.ds_n |=> vme_dtack_oe)
      else $error("acknowledge dropped early");
   a_ack_released: assert property (s_idle |-> !vme_dtack_oe && !vme_data_oe)
      else $error("bus driven while idle");
   a_am_refused: assert property (s_bad_am |-> !vme_dtack_oe && !vme_data_oe)
      else $error("wrong modifier answered");
   a_base_refused: assert property (s_bad_base |-> !vme_dtack_oe)
      else $error("wrong base answered");
   a_write_no_drive: assert property (s_writing |-> !vme_data_oe)
      else $error("data driven in write");
   a_dtack_level: assert property (vme_dtack_oe |-> !vme_dtack_n_out)
      else $error("acknowledge level high");
   a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("avalon answer late");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_strobe_pulse: assert property (update_strobe |=> !update_strobe)
      else $error("update strobe too long");
endmodule : dac_decode_checker

bind dac_decode_top dac_decode_checker checker_i (.clock, .reset, .vme_in, .vme_data_out,
   .vme_data_oe, .vme_dtack_n_out, .vme_dtack_oe, .config_in, .update_strobe, .avs_read,
   .avs_write, .avs_waitrequest);

// ===== test/vme_master_model.sv
// behavioural backplane master issuing short i/o cycles
// assumes a pulled-up acknowledge line and one cycle at a time
module vme_master_model (
   input wire logic clock,
   output dac_decode_pkg::vme_pins_t pins,
   input wire logic [15:0] vme_data_out,
   input wire logic vme_data_oe,
   input wire logic vme_dtack_n_out,
   input wire logic vme_dtack_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   import dac_decode_pkg::*;
   vme_pins_t drv = {16'hffff, 6'h3f, 3'b111, 16'hffff};
   logic ack_low;
   // open drain: low only while the slave enables its low level
   assign ack_low = vme_dtack_oe && !vme_dtack_n_out;
   // slave's read data wins while it drives the lines
   always_comb begin
      pins = drv;
      if (vme_data_oe) pins.data = vme_data_out;
   end
   // one transfer; a slave that never answers ends it after 16 edges
   task automatic cycle(input logic [15:0] a, input logic [5:0] m, input logic wr,
         input logic [15:0] wd, output logic acked, output logic [15:0] rd);
      int n;
      drv.addr <= a;
      drv.am <= m;
      drv.write_n <= !wr;
      drv.data <= wr ? wd : ~drv.data;
      @(posedge clock);
      drv.as_n <= 1'b0;
      drv.ds_n <= 1'b0;
      n = 0;
      acked = 1'b0;
      while (!acked && n < 16) begin
         @(posedge clock);
         n++;
         acked = ack_low;
      end
      rd = pins.data;
      drv.as_n <= 1'b1;
      drv.ds_n <= 1'b1;
      drv.data <= ~drv.data;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack_low && n < 16);
      // released lines show no stale value
      drv.addr <= ~a;
      drv.am <= ~m;
      @(posedge clock);
   endtask : cycle
endmodule : vme_master_model

// ===== test/tb_dac_decode_top.sv
// self-checking bench for the backplane decode and strap block
// assumes the master model file and the defs header on the include path
`include "dac_decode_defs.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("Error %s expected %h seen %h", what, exp, got); end end

module tb_dac_decode_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dac_decode_pkg::*;
   localparam logic [11:0] FACTORY = {8'hff, 4'b0100};
   localparam logic [5:0] SUP = `AM_SUPERVISORY;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic trig = 1'b0;
   vme_pins_t pins;
   config_pins_t cfg = {5'b01000, FACTORY};
   logic [15:0] vme_data_out;
   logic vme_data_oe, vme_dtack_n_out, vme_dtack_oe, update_strobe, avs_waitrequest;
   dac_bank_t dac_code;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic [15:0] r;
   logic [5:0] bad_am [4] = '{6'h29, 6'h3d, 6'h39, 6'h09};
   int fails = 0;
   int compares = 0;
   int strobes = 0;
   int cyc = 0;
   int s;

   always #2 clock = ~clock;

   dac_decode_top dut (.clock, .reset, .vme_in(pins), .vme_data_out, .vme_data_oe,
      .vme_dtack_n_out, .vme_dtack_oe, .config_in(cfg), .external_update_trigger_in(trig),
      .dac_code, .update_strobe, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
   vme_master_model master (.clock, .pins, .vme_data_out, .vme_data_oe, .vme_dtack_n_out,
      .vme_dtack_oe);

   task automatic tally_and_finish();
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // strobe tally and hang guard
   always @(posedge clock) begin
      if (update_strobe === 1'b1) strobes++;
      cyc++;
      if (cyc == 30000) begin
         fails++;
         tally_and_finish();
      end
   end

   // avalon access held until waitrequest is sampled low
   task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] wd,
         output logic [31:0] d);
      int n;
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : av

   task automatic vw(input logic [15:0] a, input logic [5:0] m, input logic wr,
         input logic [15:0] wd, input logic ea, output logic [15:0] d);
      logic ak;
      master.cycle(a, m, wr, wd, ak, d);
      `CHK("dtack", ea, ak)
   endtask : vw

   // straps are synchronised, so let them settle before traffic
   task automatic setcfg(input config_pins_t c);
      cfg <= c;
      repeat (6) @(posedge clock);
   endtask : setcfg

   task automatic wait_strobe(input int base);
      int n;
      n = 0;
      while (strobes == base && n < 60) begin
         @(posedge clock);
         n++;
      end
      `CHK("strobes", base + 1, strobes)
   endtask : wait_strobe

   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      // synchronisers restart from zero; let the straps reach the decode first
      repeat (3) @(posedge clock);
      av(4'h0, 1'b0, 32'h0, rd);
      `CHK("status", 32'h301, rd)
      av(4'h2, 1'b0, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      // immediate mode, every channel word
      for (int i = 0; i < 8; i++) begin
         vw(16'h0060 + 16'(2 * i), SUP, 1'b1, {i[3:0], 12'h5a3}, 1'b1, r);
         `CHK("channel", {i[3:0], 12'h5a3}, dac_code[i])
         `CHK("strobes", i + 1, strobes)
      end
      vw(16'h006e, SUP, 1'b0, 16'h0, 1'b1, r);
      `CHK("readback", 16'h75a3, r)
      vw(16'h007e, SUP, 1'b0, 16'h0, 1'b1, r);
      foreach (bad_am[k]) vw(16'h0060, bad_am[k], 1'b1, 16'hdead, 1'b0, r);
      for (int b = 5; b < 16; b++) vw(16'h0060 ^ 16'(1 << b), SUP, 1'b1, 16'h0, 1'b0, r);
      setcfg({5'b11000, FACTORY});
      vw(16'h0062, `AM_NONPRIVILEGED, 1'b1, 16'h1234, 1'b1, r);
      vw(16'h0062, SUP, 1'b1, 16'h4321, 1'b0, r);
      `CHK("channel", 16'h1234, dac_code[1])
      // other switch setting, spare position set
      setcfg({5'b01000, 8'h43, 4'b1101});
      vw(16'hbc44, SUP, 1'b1, 16'h0bc4, 1'b1, r);
      vw(16'h0064, SUP, 1'b1, 16'h0, 1'b0, r);
      `CHK("channel", 16'h0bc4, dac_code[2])
      setcfg({5'b00100, FACTORY});
      vw(16'h0060, SUP, 1'b1, 16'h0001, 1'b1, r);
      `CHK("twos", 16'h8001, dac_code[0])
      vw(16'h0060, SUP, 1'b0, 16'h0, 1'b1, r);
      `CHK("twos read", 16'h0001, r)
      // program mode: held until a start
      setcfg({5'b01010, FACTORY});
      s = strobes;
      vw(16'h0066, SUP, 1'b1, 16'h5a5a, 1'b1, r);
      `CHK("held", 16'h35a3, dac_code[3])
      `CHK("strobes", s, strobes)
      vw(16'h0070, SUP, 1'b1, 16'h0001, 1'b1, r);
      wait_strobe(s);
      `CHK("channel", 16'h5a5a, dac_code[3])
      av(4'h0, 1'b0, 32'h0, rd);
      `CHK("status", 32'h302, rd)
      vw(16'h0068, SUP, 1'b1, 16'h6b6b, 1'b1, r);
      av(4'h4, 1'b1, 32'h3, rd);
      wait_strobe(s + 1);
      `CHK("channel", 16'h6b6b, dac_code[4])
      setcfg({5'b01001, FACTORY});
      vw(16'h006a, SUP, 1'b1, 16'h7c7c, 1'b1, r);
      `CHK("channel", 16'h7c7c, dac_code[5])
      // external mode ignores software starts
      setcfg({5'b01011, FACTORY});
      s = strobes;
      vw(16'h006c, SUP, 1'b1, 16'h8d8d, 1'b1, r);
      vw(16'h0070, SUP, 1'b1, 16'h0001, 1'b1, r);
      repeat (20) @(posedge clock);
      `CHK("strobes", s, strobes)
      trig <= 1'b1;
      wait_strobe(s);
      trig <= 1'b0;
      `CHK("channel", 16'h8d8d, dac_code[6])
      // twenty cycles were acknowledged; the last was the csr write
      av(4'h8, 1'b0, 32'h0, rd);
      `CHK("cycles", 32'h14, rd)
      av(4'hc, 1'b0, 32'h0, rd);
      `CHK("last addr", 32'h10070, rd)
      tally_and_finish();
   end
endmodule : tb_dac_decode_top
